// ---- design/erfh_consts.svh ----
// Offsets, field positions, reset values and fixed codes of the fault unit
//
// Contract
// - Return starts only in Handler mode via pop-with-PC, register branch, or PC load.
// - Return code has bits 31..4 all ones; loading it into PC ends handler.
// - Only the low nibble is decoded; nibbles xxx0, 0011, 01x1, 1x11 are reserved.
// - 0001 handler/main stack, 1001 thread/main stack, 1101 thread/process stack.
// - Bus errors, internal errors and execute-never fetches all raise faults.
// - Vector read bus error goes to hard fault; escalation sets its own flag.
// - Bus faults flag push, pop, prefetch, exact data and inexact data separately.
// - Usage faults flag coprocessor, opcode, ISA state, return code, misalign, divide.
// - Non-hard fault classes have programmable priority and a handler enable.
// - Fault in a fault handler of equal or lower priority escalates.
// - Any handler faulting at equal or lower priority escalates to hard fault.
// - A fault whose handler is disabled escalates to hard fault.
// - Push bus error entering the bus fault handler never escalates; the code still escalates it in NMI or hard fault context.
// - Hard fault preempts all but reset, NMI, hard fault; only those preempt it.
// - Bus and memory-management faults capture the faulting access address.
// - Hard fault inside NMI or hard fault handler enters lockup.
// - Lockup ends by reset or NMI; NMI cannot release lockup entered from NMI.
// - Stack frame is eight words: r0-r3, r12, link, return address, status.
// - Numerically lower priority value means higher urgency.
`ifndef ERFH_CONSTS_SVH
`define ERFH_CONSTS_SVH

`define ERFH_RET_TOP        28'hfffffff
`define ERFH_RET_H_MAIN     4'h1
`define ERFH_RET_T_MAIN     4'h9
`define ERFH_RET_T_PROC     4'hd
`define ERFH_FRAME_WORDS    4'h8

`define ERFH_OFF_CTRL       12'h000
`define ERFH_OFF_HFS        12'h004
`define ERFH_OFF_MMFS       12'h008
`define ERFH_OFF_BFS        12'h00c
`define ERFH_OFF_UFS        12'h010
`define ERFH_OFF_MMFA       12'h014
`define ERFH_OFF_BFA        12'h018
`define ERFH_OFF_STATE      12'h01c

`define ERFH_CTRL_RST       32'h00000000
`define ERFH_STAT_RST       32'h00000000
`define ERFH_CTRL_MEM_PRIO  0
`define ERFH_CTRL_BUS_PRIO  4
`define ERFH_CTRL_USE_PRIO  8
`define ERFH_CTRL_MEM_EN    16
`define ERFH_CTRL_BUS_EN    17
`define ERFH_CTRL_USE_EN    18

`define ERFH_HF_VEC         1
`define ERFH_HF_ESC         30
`define ERFH_MM_XN          0
`define ERFH_MM_DACC        1
`define ERFH_MM_AVALID      7
`define ERFH_BF_PREFETCH    0
`define ERFH_BF_EXACT       1
`define ERFH_BF_INEXACT     2
`define ERFH_BF_POP         3
`define ERFH_BF_PUSH        4
`define ERFH_BF_AVALID      7
`define ERFH_UF_UNDEF       0
`define ERFH_UF_ISA         1
`define ERFH_UF_RET         2
`define ERFH_UF_COPROC      3
`define ERFH_UF_ALIGN       8
`define ERFH_UF_DIV         9

`endif

// ---- design/erfh_pkg.sv ----
// Types and shared helper functions of the fault unit
package erfh_pkg;

    typedef enum logic [3:0] {
        C_VEC = 4'h0, C_PUSH = 4'h1, C_POP = 4'h2, C_PREFETCH = 4'h3,
        C_EXACT = 4'h4, C_INEXACT = 4'h5, C_EXEC_NEVER = 4'h6, C_MEM_DATA = 4'h7,
        C_COPROC = 4'h8, C_UNDEF = 4'h9, C_BAD_ISA = 4'ha, C_BAD_RET = 4'hb,
        C_MISALIGN = 4'hc, C_ZERO_DIV = 4'hd
    } erfh_cause_t;

    typedef enum logic [1:0] {
        K_HARD = 2'h0, K_MEM = 2'h1, K_BUS = 2'h2, K_USAGE = 2'h3
    } erfh_class_t;

    typedef enum logic [1:0] {
        X_THREAD = 2'h0, X_HANDLER = 2'h1, X_HARD = 2'h2, X_NMI = 2'h3
    } erfh_ctx_t;

    typedef enum logic [1:0] {
        P_POP_PC = 2'h0, P_BRANCH_REG = 2'h1, P_LOAD_PC = 2'h2, P_OTHER = 2'h3
    } erfh_pc_kind_t;

    typedef enum logic [2:0] {
        LK_RUN = 3'b001, LK_HARD = 3'b010, LK_NMI = 3'b100
    } erfh_lock_t;

    typedef struct packed {
        logic          valid;
        erfh_pc_kind_t kind;
        logic [31:0]   value;
    } erfh_pc_load_t;

    typedef struct packed {
        logic        valid;
        erfh_cause_t cause;
        logic        addr_ok;
        logic [31:0] addr;
    } erfh_fault_t;

    // Maps a cause onto the handler class that normally takes it
    function automatic erfh_class_t cause_class(input erfh_cause_t c);
        if (c == C_VEC)
            return K_HARD;
        else if (c == C_EXEC_NEVER || c == C_MEM_DATA)
            return K_MEM;
        else if (c <= C_INEXACT)
            return K_BUS;
        else
            return K_USAGE;
    endfunction : cause_class

    // Sticky flag update; a new event beats a software clear
    function automatic logic [31:0] sticky(input logic [31:0] old,
                                           input logic [31:0] set,
                                           input logic [31:0] clr);
        return set | (old & ~clr);
    endfunction : sticky

endpackage : erfh_pkg

// ---- design/erfh_ret_decode.sv ----
// Decoder for the handler return code loaded into the program counter
`timescale 1ns/100ps
`include "erfh_consts.svh"
module erfh_ret_decode (
    input  wire logic [31:0] code,
    output wire logic        is_code,
    output wire logic        legal,
    output wire logic        to_thread,
    output wire logic        use_psp
);
    wire logic [3:0] nib;

    // Top bits mark the code, low nibble picks mode and stack
    assign nib       = code[3:0];
    assign is_code   = (code[31:4] == `ERFH_RET_TOP);
    assign legal     = (nib == `ERFH_RET_H_MAIN) || (nib == `ERFH_RET_T_MAIN)
                    || (nib == `ERFH_RET_T_PROC);
    assign to_thread = nib[3];
    assign use_psp   = nib[2];
endmodule : erfh_ret_decode

// ---- design/erfh_prio_cmp.sv ----
// Priority comparator: true when a new priority preempts the running one
`timescale 1ns/100ps
module erfh_prio_cmp #(
    parameter int W = 4
) (
    input  wire logic [W-1:0] new_prio,
    input  wire logic [W-1:0] cur_prio,
    output wire logic         preempts
);
    // Lower value is more urgent; equal never preempts
    assign preempts = (new_prio < cur_prio);
endmodule : erfh_prio_cmp

// ---- design/erfh_top.sv ----
// Exception return detection, fault classification, escalation and lockup
`timescale 1ns/100ps
`include "erfh_consts.svh"
module erfh_top #(
    parameter int PW = 4
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output wire logic                   pready,
    output wire logic                   pslverr,
    input  wire logic                   handler_mode,
    input  wire erfh_pkg::erfh_pc_load_t pc_load,
    input  wire erfh_pkg::erfh_fault_t  fault_in,
    input  wire erfh_pkg::erfh_ctx_t    ctx,
    input  wire logic [PW-1:0]          exec_prio,
    input  wire logic                   entering_bus_handler,
    input  wire logic                   nmi_event,
    output logic                        ret_start,
    output logic                        ret_to_thread,
    output logic                        ret_use_psp,
    output logic      [3:0]             ret_frame_words,
    output logic                        fault_take,
    output erfh_pkg::erfh_class_t       fault_target,
    output wire logic                   lockup
);
    logic [31:0]          ctrl;
    logic [31:0]          hard_fault_status;
    logic [31:0]          memmanage_fault_status;
    logic [31:0]          bus_fault_status;
    logic [31:0]          usage_fault_status;
    logic [31:0]          memmanage_fault_address;
    logic [31:0]          bus_fault_address;
    erfh_pkg::erfh_lock_t lk;
    erfh_pkg::erfh_lock_t next_lk;
    logic [31:0]          set_hf;
    logic [31:0]          set_mm;
    logic [31:0]          set_bf;
    logic [31:0]          set_uf;

    wire logic                  ret_is_code;
    wire logic                  ret_legal;
    wire logic                  ret_thread;
    wire logic                  ret_psp;
    wire logic                  kind_ok;
    wire logic                  ret_hit;
    wire logic                  ret_good;
    wire logic                  ret_bad;
    wire logic                  running;
    wire logic                  eff_valid;
    wire erfh_pkg::erfh_cause_t eff_cause;
    wire erfh_pkg::erfh_class_t cls;
    wire logic [PW-1:0]         cls_prio;
    wire logic                  cls_en;
    wire logic                  preempt;
    wire logic                  fixed_ctx;
    wire logic                  exempt;
    wire logic                  to_hard;
    wire logic                  escalated;
    wire logic                  go_lock;
    wire logic                  cap_mm;
    wire logic                  cap_bf;

    // Return code decode
    erfh_ret_decode u_dec (
        .code      (pc_load.value),
        .is_code   (ret_is_code),
        .legal     (ret_legal),
        .to_thread (ret_thread),
        .use_psp   (ret_psp)
    );

    // Return only from Handler mode through the three PC-writing forms
    assign kind_ok  = (pc_load.kind != erfh_pkg::P_OTHER);
    assign ret_hit  = pc_load.valid && handler_mode && kind_ok && ret_is_code;
    assign ret_good = ret_hit && ret_legal && running;
    assign ret_bad  = ret_hit && !ret_legal;

    // Fault source select; a reported fault outranks a bad return code
    assign running   = (lk == erfh_pkg::LK_RUN);
    assign eff_valid = (fault_in.valid || ret_bad) && running;
    assign eff_cause = fault_in.valid ? fault_in.cause : erfh_pkg::C_BAD_RET;
    assign cls       = erfh_pkg::cause_class(eff_cause);

    // Per-class priority and enable from the control register
    assign cls_prio = (cls == erfh_pkg::K_MEM) ? ctrl[`ERFH_CTRL_MEM_PRIO +: PW] :
                      (cls == erfh_pkg::K_BUS) ? ctrl[`ERFH_CTRL_BUS_PRIO +: PW] :
                      ctrl[`ERFH_CTRL_USE_PRIO +: PW];
    assign cls_en   = (cls == erfh_pkg::K_MEM) ? ctrl[`ERFH_CTRL_MEM_EN] :
                      (cls == erfh_pkg::K_BUS) ? ctrl[`ERFH_CTRL_BUS_EN] :
                      ctrl[`ERFH_CTRL_USE_EN];

    // Can the new fault preempt the running handler
    erfh_prio_cmp #(
        .W (PW)
    ) u_cmp (
        .new_prio (cls_prio),
        .cur_prio (exec_prio),
        .preempts (preempt)
    );

    // Escalation decision
    assign fixed_ctx = (ctx == erfh_pkg::X_HARD) || (ctx == erfh_pkg::X_NMI);
    assign exempt    = (eff_cause == erfh_pkg::C_PUSH) && entering_bus_handler;
    assign to_hard   = (cls == erfh_pkg::K_HARD) || fixed_ctx
                     || (!exempt && (!cls_en
                     || (ctx == erfh_pkg::X_HANDLER && !preempt)));
    assign escalated = to_hard && (cls != erfh_pkg::K_HARD);
    assign go_lock   = eff_valid && to_hard && fixed_ctx;

    // Address capture only for memory-management and bus faults
    assign cap_mm = eff_valid && fault_in.valid && fault_in.addr_ok
                 && (cls == erfh_pkg::K_MEM);
    assign cap_bf = eff_valid && fault_in.valid && fault_in.addr_ok
                 && (cls == erfh_pkg::K_BUS);

    // Per-cause flag set vectors
    always_comb
    begin
        set_hf = '0;
        set_mm = '0;
        set_bf = '0;
        set_uf = '0;
        if (eff_valid)
        begin
            set_hf[`ERFH_HF_VEC]      = (eff_cause == erfh_pkg::C_VEC);
            set_hf[`ERFH_HF_ESC]      = escalated;
            set_mm[`ERFH_MM_XN]       = (eff_cause == erfh_pkg::C_EXEC_NEVER);
            set_mm[`ERFH_MM_DACC]     = (eff_cause == erfh_pkg::C_MEM_DATA);
            set_mm[`ERFH_MM_AVALID]   = cap_mm;
            set_bf[`ERFH_BF_PUSH]     = (eff_cause == erfh_pkg::C_PUSH);
            set_bf[`ERFH_BF_POP]      = (eff_cause == erfh_pkg::C_POP);
            set_bf[`ERFH_BF_PREFETCH] = (eff_cause == erfh_pkg::C_PREFETCH);
            set_bf[`ERFH_BF_EXACT]    = (eff_cause == erfh_pkg::C_EXACT);
            set_bf[`ERFH_BF_INEXACT]  = (eff_cause == erfh_pkg::C_INEXACT);
            set_bf[`ERFH_BF_AVALID]   = cap_bf;
            set_uf[`ERFH_UF_COPROC]   = (eff_cause == erfh_pkg::C_COPROC);
            set_uf[`ERFH_UF_UNDEF]    = (eff_cause == erfh_pkg::C_UNDEF);
            set_uf[`ERFH_UF_ISA]      = (eff_cause == erfh_pkg::C_BAD_ISA);
            set_uf[`ERFH_UF_RET]      = (eff_cause == erfh_pkg::C_BAD_RET);
            set_uf[`ERFH_UF_ALIGN]    = (eff_cause == erfh_pkg::C_MISALIGN);
            set_uf[`ERFH_UF_DIV]      = (eff_cause == erfh_pkg::C_ZERO_DIV);
        end
    end

    // APB decode; zero wait states, read data latched in the setup cycle
    wire logic        setup_ph;
    wire logic        wr_acc;
    wire logic        addr_hit;
    wire logic [31:0] rd_mux;
    wire logic [31:0] clr_hf;
    wire logic [31:0] clr_mm;
    wire logic [31:0] clr_bf;
    wire logic [31:0] clr_uf;

    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign addr_hit = (paddr <= `ERFH_OFF_STATE) && (paddr[1:0] == 2'h0);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !addr_hit;
    assign rd_mux   = (paddr == `ERFH_OFF_CTRL)  ? ctrl :
                      (paddr == `ERFH_OFF_HFS)   ? hard_fault_status :
                      (paddr == `ERFH_OFF_MMFS)  ? memmanage_fault_status :
                      (paddr == `ERFH_OFF_BFS)   ? bus_fault_status :
                      (paddr == `ERFH_OFF_UFS)   ? usage_fault_status :
                      (paddr == `ERFH_OFF_MMFA)  ? memmanage_fault_address :
                      (paddr == `ERFH_OFF_BFA)   ? bus_fault_address :
                      (paddr == `ERFH_OFF_STATE) ? {30'h0, lk == erfh_pkg::LK_NMI, lockup} :
                      32'h0;

    // Write-one-to-clear masks for the status registers
    assign clr_hf = (wr_acc && paddr == `ERFH_OFF_HFS)  ? pwdata : 32'h0;
    assign clr_mm = (wr_acc && paddr == `ERFH_OFF_MMFS) ? pwdata : 32'h0;
    assign clr_bf = (wr_acc && paddr == `ERFH_OFF_BFS)  ? pwdata : 32'h0;
    assign clr_uf = (wr_acc && paddr == `ERFH_OFF_UFS)  ? pwdata : 32'h0;

    // Read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup_ph)
            prdata <= rd_mux;
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl <= `ERFH_CTRL_RST;
        else if (wr_acc && paddr == `ERFH_OFF_CTRL)
            ctrl <= pwdata & 32'h0007_0fff;
    end

    // Sticky status flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hard_fault_status      <= `ERFH_STAT_RST;
            memmanage_fault_status <= `ERFH_STAT_RST;
            bus_fault_status       <= `ERFH_STAT_RST;
            usage_fault_status     <= `ERFH_STAT_RST;
        end
        else
        begin
            hard_fault_status      <= erfh_pkg::sticky(hard_fault_status, set_hf, clr_hf);
            memmanage_fault_status <= erfh_pkg::sticky(memmanage_fault_status, set_mm, clr_mm);
            bus_fault_status       <= erfh_pkg::sticky(bus_fault_status, set_bf, clr_bf);
            usage_fault_status     <= erfh_pkg::sticky(usage_fault_status, set_uf, clr_uf);
        end
    end

    // Fault address capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            memmanage_fault_address <= 32'h0;
            bus_fault_address       <= 32'h0;
        end
        else
        begin
            if (cap_mm)
                memmanage_fault_address <= fault_in.addr;
            if (cap_bf)
                bus_fault_address <= fault_in.addr;
        end
    end

    // Lockup state: NMI releases only a lockup entered from hard fault
    always_comb
    begin
        next_lk = lk;
        unique case (lk)
            erfh_pkg::LK_RUN:
                if (go_lock)
                    next_lk = (ctx == erfh_pkg::X_NMI) ? erfh_pkg::LK_NMI
                                                       : erfh_pkg::LK_HARD;
            erfh_pkg::LK_HARD:
                if (nmi_event)
                    next_lk = erfh_pkg::LK_RUN;
            erfh_pkg::LK_NMI:
                next_lk = erfh_pkg::LK_NMI;
            default:
                next_lk = erfh_pkg::LK_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lk <= erfh_pkg::LK_RUN;
        else
            lk <= next_lk;
    end

    assign lockup = !running;

    // Pipeline-facing result pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ret_start       <= 1'b0;
            ret_to_thread   <= 1'b0;
            ret_use_psp     <= 1'b0;
            ret_frame_words <= 4'h0;
            fault_take      <= 1'b0;
            fault_target    <= erfh_pkg::K_HARD;
        end
        else
        begin
            ret_start       <= ret_good && running;
            ret_to_thread   <= ret_good && ret_thread;
            ret_use_psp     <= ret_good && ret_psp;
            ret_frame_words <= ret_good ? `ERFH_FRAME_WORDS : 4'h0;
            fault_take      <= eff_valid && !go_lock;
            fault_target    <= to_hard ? erfh_pkg::K_HARD : cls;
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_lock_from_nmi;
        go_lock && ctx == erfh_pkg::X_NMI && running ##1 lockup;
    endsequence

    sequence s_faulty_disabled;
        eff_valid && !fixed_ctx && !cls_en && !exempt && cls != erfh_pkg::K_HARD;
    endsequence

    chk_ret_handler_only: assert property (ret_start |->
        $past(handler_mode && pc_load.valid && pc_load.kind != erfh_pkg::P_OTHER))
        else $error("return started outside handler mode");
    chk_ret_code_top: assert property (ret_start |->
        $past(pc_load.value[31:4]) == 28'hfffffff)
        else $error("return started without return code pattern");
    chk_ret_reserved: assert property (ret_hit && !ret_legal && !fault_in.valid && running
        |=> !ret_start && usage_fault_status[2])
        else $error("reserved return code not flagged");
    chk_ret_psp_mode: assert property (ret_start && ret_use_psp |->
        ret_to_thread && ret_frame_words == 4'h8)
        else $error("process stack return not to thread");
    chk_vec_hard: assert property (eff_valid && eff_cause == erfh_pkg::C_VEC && !fixed_ctx
        |=> fault_take && fault_target == erfh_pkg::K_HARD && hard_fault_status[1])
        else $error("vector read error not hard fault");
    chk_disabled_esc: assert property (s_faulty_disabled |=>
        fault_target == erfh_pkg::K_HARD && hard_fault_status[30])
        else $error("disabled handler fault not escalated");
    chk_equal_prio_esc: assert property (eff_valid && ctx == erfh_pkg::X_HANDLER && cls_en
        && !exempt && cls_prio >= exec_prio |=> fault_target == erfh_pkg::K_HARD)
        else $error("non-preempting fault not escalated");
    chk_push_exempt: assert property (eff_valid && exempt && !fixed_ctx
        |=> fault_target == erfh_pkg::K_BUS && !$rose(hard_fault_status[30]))
        else $error("bus handler push error escalated");
    chk_nmi_lock_hold: assert property (s_lock_from_nmi ##1 nmi_event |=> lockup[*4])
        else $error("nmi released lockup entered from nmi");
    chk_hard_lock: assert property (eff_valid && ctx == erfh_pkg::X_HARD
        |=> lockup && !fault_take)
        else $error("hard fault in hard handler did not lock");
    chk_flag_sticky: assert property (usage_fault_status[9] && !clr_uf[9]
        |=> usage_fault_status[9])
        else $error("fault flag dropped without clear");
    chk_bus_addr: assert property (cap_bf |=> bus_fault_address == $past(fault_in.addr))
        else $error("bus fault address not captured");

endmodule : erfh_top

// ---- testbench/erfh_core_model.sv ----
// Model of pipeline, bus interface and prioritiser beside the fault unit
`timescale 1ns/100ps
module erfh_core_model (
    input  wire logic               pclk,
    output logic                    handler_mode = 1'b1,
    output erfh_pkg::erfh_pc_load_t pc_load = '0,
    output erfh_pkg::erfh_fault_t   fault_in = '0,
    output erfh_pkg::erfh_ctx_t     ctx = erfh_pkg::X_THREAD,
    output logic [3:0]              exec_prio = 4'h0,
    output logic                    entering_bus_handler = 1'b0,
    output logic                    nmi_event = 1'b0
);
    // Running context, changed just after an edge
    task automatic set_ctx(input logic [1:0] c, input logic [3:0] p, input logic b);
        @(posedge pclk);
        ctx <= erfh_pkg::erfh_ctx_t'(c);
        exec_prio <= p;
        entering_bus_handler <= b;
    endtask : set_ctx
    // Handler mode level, changed just after an edge
    task automatic mode(input logic h);
        @(posedge pclk);
        handler_mode <= h;
    endtask : mode
    // One-cycle fault report; address scrambled once released
    task automatic fault(input logic [3:0] c, input logic [31:0] a);
        @(posedge pclk);
        fault_in <= '{1'b1, erfh_pkg::erfh_cause_t'(c), 1'b1, a};
        @(posedge pclk);
        fault_in <= '{1'b0, erfh_pkg::erfh_cause_t'(c), 1'b0, ~a};
    endtask : fault
    // One-cycle program counter load of the given kind
    task automatic pc(input logic [1:0] k, input logic [31:0] v);
        @(posedge pclk);
        pc_load <= '{1'b1, erfh_pkg::erfh_pc_kind_t'(k), v};
        @(posedge pclk);
        pc_load <= '{1'b0, erfh_pkg::erfh_pc_kind_t'(k), ~v};
    endtask : pc
    // One-cycle non-maskable interrupt
    task automatic nmi;
        @(posedge pclk);
        nmi_event <= 1'b1;
        @(posedge pclk);
        nmi_event <= 1'b0;
    endtask : nmi
endmodule : erfh_core_model

// ---- testbench/test_exception_return_fault_handling.sv ----
// Self-checking bench of the return, fault and lockup unit
`timescale 1ns/100ps
module test_exception_return_fault_handling;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, ret_start, ret_to_thread, ret_use_psp;
    logic        fault_take, lockup, handler_mode, entering_bus_handler, nmi_event;
    logic [3:0]  ret_frame_words, exec_prio;
    logic [3:0]  nib [4] = '{4'h1, 4'h9, 4'hd, 4'h3};
    logic [6:0]  rex [4] = '{7'h48, 7'h68, 7'h78, 7'h00};
    int          n_errors = 0, cmp_count = 0, cycles = 0;
    erfh_pkg::erfh_pc_load_t pc_load;
    erfh_pkg::erfh_fault_t   fault_in;
    erfh_pkg::erfh_ctx_t     ctx;
    erfh_pkg::erfh_class_t   fault_target;
    // Clock and hang limit
    always #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    erfh_top #(.PW(4)) erfh_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .handler_mode(handler_mode), .pc_load(pc_load),
        .fault_in(fault_in), .ctx(ctx), .exec_prio(exec_prio), .nmi_event(nmi_event),
        .entering_bus_handler(entering_bus_handler), .ret_start(ret_start),
        .ret_to_thread(ret_to_thread), .ret_use_psp(ret_use_psp), .lockup(lockup),
        .ret_frame_words(ret_frame_words), .fault_take(fault_take), .fault_target(fault_target));
    erfh_core_model erfh_core_model_i (.pclk(pclk), .handler_mode(handler_mode),
        .pc_load(pc_load), .fault_in(fault_in), .ctx(ctx), .exec_prio(exec_prio),
        .entering_bus_handler(entering_bus_handler), .nmi_event(nmi_event));
    // Verdict and end of run
    task automatic give_verdict;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer, held until pready at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // Read a register and compare data and error
    task automatic rck(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, '0);
        chk(rd, exp);
        chk(err, e);
    endtask : rck
    // Report a fault and compare take and target
    task automatic flt(input logic [3:0] c, input logic [31:0] a, input logic [1:0] t);
        erfh_core_model_i.fault(c, a);
        #1;
        chk({fault_take, fault_target}, {1'b1, t});
    endtask : flt
    // Main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rck(12'h000, 32'h0, 1'b0);
        rck(12'h020, 32'h0, 1'b1);
        flt(4'h9, 32'h0, 2'h0);
        rck(12'h004, 32'h40000000, 1'b0);
        rck(12'h010, 32'h1, 1'b0);
        rck(12'h004, 32'h40000000, 1'b0);
        apb(1'b1, 12'h004, 32'h40000000);
        rck(12'h004, 32'h0, 1'b0);
        apb(1'b1, 12'h000, 32'h00070123);
        flt(4'h4, 32'h1234, 2'h2);
        rck(12'h00c, 32'h82, 1'b0);
        rck(12'h018, 32'h1234, 1'b0);
        flt(4'h6, 32'h55aa, 2'h1);
        rck(12'h014, 32'h55aa, 1'b0);
        rck(12'h008, 32'h81, 1'b0);
        erfh_core_model_i.set_ctx(2'h1, 4'h1, 1'b0);
        flt(4'hd, 32'h0, 2'h0);
        erfh_core_model_i.set_ctx(2'h1, 4'h2, 1'b0);
        flt(4'hd, 32'h0, 2'h3);
        erfh_core_model_i.set_ctx(2'h1, 4'h2, 1'b1);
        flt(4'h1, 32'h0, 2'h2);
        erfh_core_model_i.set_ctx(2'h0, 4'h0, 1'b0);
        flt(4'h0, 32'h0, 2'h0);
        rck(12'h004, 32'h40000002, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            erfh_core_model_i.pc(2'(i % 3), {28'hfffffff, nib[i]});
            #1;
            chk({ret_start, ret_to_thread, ret_use_psp, ret_frame_words}, rex[i]);
        end
        chk({fault_take, fault_target}, 3'h7);
        erfh_core_model_i.pc(2'h3, 32'hfffffffd);
        #1;
        chk(ret_start, 1'b0);
        erfh_core_model_i.pc(2'h1, 32'h7ffffffd);
        #1;
        chk({ret_start, fault_take}, 2'b00);
        erfh_core_model_i.mode(1'b0);
        erfh_core_model_i.pc(2'h1, 32'hfffffffd);
        #1;
        chk(ret_start, 1'b0);
        erfh_core_model_i.mode(1'b1);
        erfh_core_model_i.set_ctx(2'h2, 4'h0, 1'b0);
        erfh_core_model_i.fault(4'h9, 32'h0);
        #1;
        chk({fault_take, lockup}, 2'b01);
        erfh_core_model_i.nmi();
        #1;
        chk(lockup, 1'b0);
        erfh_core_model_i.set_ctx(2'h3, 4'h0, 1'b0);
        erfh_core_model_i.fault(4'h9, 32'h0);
        erfh_core_model_i.nmi();
        #1;
        chk(lockup, 1'b1);
        rck(12'h01c, 32'h3, 1'b0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(lockup, 1'b0);
        give_verdict();
    end
endmodule : test_exception_return_fault_handling
